/* File: src/fpu_exc_pkg.sv */
// Purpose: shared constants and types for the fp exception unit
// Assumes: single (8/23) and double (11/52) formats, 32-bit control/status word
// Notes:   register offsets are byte addresses on the axi4-lite port
package fpu_exc_pkg;

    localparam logic [7:0] OFF_CSR      = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_COUNT    = 8'h08;

    // control/status word layout
    localparam int RM_LO       = 0;
    localparam int FLAG_LO     = 2;
    localparam int EN_LO       = 7;
    localparam int CAUSE_LO    = 12;
    localparam int FLUSH_SEL   = 24;
    localparam logic [31:0] CSR_RESET = 32'h0000_0000;
    localparam logic [31:0] CSR_WMASK = 32'h0103_ffff;

    // exception bit indices inside the five-bit and six-bit fields
    localparam int X_I = 0;
    localparam int X_U = 1;
    localparam int X_O = 2;
    localparam int X_Z = 3;
    localparam int X_V = 4;
    localparam int X_E = 5;

    localparam logic [1:0] RM_NEAR  = 2'h0;
    localparam logic [1:0] RM_ZERO  = 2'h1;
    localparam logic [1:0] RM_PINF  = 2'h2;
    localparam logic [1:0] RM_MINF  = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [63:0] QNAN_D  = 64'h7ff8_0000_0000_0000;
    localparam logic [63:0] QNAN_S  = 64'h0000_0000_7fc0_0000;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT, OP_ABS, OP_NEG, OP_MOVE,
        OP_CMP, OP_CVT_S, OP_CVT_D, OP_CVT_W, OP_CVT_L, OP_RSVD
    } fp_op_t;

    typedef enum logic [1:0] {FMT_S, FMT_D, FMT_W, FMT_L} fp_fmt_t;

    typedef enum logic [1:0] {CL_NUM, CL_ZERO, CL_INF, CL_NAN} fp_cls_t;

endpackage

/* File: src/fp_classify.sv */
// Purpose: classify one operand of either binary format
// Assumes: single values sit in the low 32 bits
// Notes:   purely combinational
`timescale 1ns/1ps
module fp_classify
    import fpu_exc_pkg::*;
(
    input  wire logic [63:0] value,
    input  wire logic        dbl,
    output logic             is_zero,
    output logic             is_inf,
    output logic             is_nan,
    output logic             is_snan,
    output logic             is_qnan,
    output logic             is_denorm,
    output logic             sign
);
    logic [10:0] ex;
    logic [51:0] man;
    logic        e_max;
    logic        e_min;
    logic        quiet;

    always_comb begin
        ex    = dbl ? value[62:52] : {3'h0, value[30:23]};
        man   = dbl ? value[51:0]  : {29'h0, value[22:0]};
        sign  = dbl ? value[63]    : value[31];
        quiet = dbl ? value[51]    : value[22];
        e_max = dbl ? (ex == 11'h7ff) : (ex == 11'h0ff);
        e_min = (ex == 11'h000);
        is_zero   = e_min && (man == 52'h0);
        is_denorm = e_min && (man != 52'h0);
        is_inf    = e_max && (man == 52'h0);
        is_nan    = e_max && (man != 52'h0);
        is_qnan   = is_nan && quiet;
        is_snan   = is_nan && !quiet;
    end
endmodule

/* File: src/fpu_exception_detect.sv */
// Purpose: fp exception classification, trap decision and result select
// Assumes: arithmetic datapath supplies rounded result and its range flags
// Notes:   one instruction per cycle; verdict registered one cycle later
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - flag invalid for inf-inf, 0*inf, 0/0, inf/inf, sqrt(neg)
// - ordered compare on unordered operands is invalid
// - signaling nan into arithmetic, abs, neg: invalid
// - compare or convert of signaling nan: invalid
// - invalid untrapped delivers a quiet nan
// - enabled trap suppresses write, keeps sources
// - divide by zero only for finite nonzero dividend
// - untrapped divide by zero gives signed infinity
// - overflow when rounded magnitude exceeds largest finite
// - overflow always also raises inexact
// - untrapped overflow result from rounding mode, sign
// - tininess judged after rounding
// - accuracy loss judged as inexact result
// - underflow with enables or flush clear: unimplemented trap
// - flushed underflow result from rounding mode, sign
// - reserved opcode or format: unimplemented, trap
// - denormal or quiet nan operand: unimplemented, not compare or move
// - self-format convert or bad format: unimplemented
// - register moves never trap
// - unimplemented trap cannot be disabled
// - writing zero cause clears pending exceptions
// - overflow/underflow and inexact both set
// - inexact on rounding, overflow, flushed underflow
module fpu_exception_detect
    import fpu_exc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // instruction issue from the integer pipeline
    input  wire logic        op_valid,
    input  wire fp_op_t      op_code,
    input  wire fp_fmt_t     op_fmt,
    input  wire logic        cmp_signals_unordered,
    input  wire logic [63:0] src_a,
    input  wire logic [63:0] src_b,
    input  wire logic [63:0] dp_result,
    input  wire logic        dp_inexact,
    input  wire logic        dp_overflow,
    input  wire logic        dp_tiny,
    input  wire logic        dp_sign,
    // verdict toward the register file and trap logic
    output logic             wb_valid,
    output logic             wb_write_en,
    output logic [63:0]      wb_data,
    output logic             fp_trap,
    output logic [5:0]       trap_cause,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef struct packed {
        logic [31:0] csr;
        logic [15:0] trap_count;
        logic        wb_valid;
        logic        wb_write_en;
        logic [63:0] wb_data;
        logic        fp_trap;
        logic [5:0]  trap_cause;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    logic a_zero, a_inf, a_nan, a_snan, a_qnan, a_den, a_sign;
    logic b_zero, b_inf, b_nan, b_snan, b_qnan, b_den, b_sign;
    logic dbl;

    assign dbl = (op_fmt == FMT_D);

    fp_classify u_cls_a (
        .value     (src_a),
        .dbl       (dbl),
        .is_zero   (a_zero),
        .is_inf    (a_inf),
        .is_nan    (a_nan),
        .is_snan   (a_snan),
        .is_qnan   (a_qnan),
        .is_denorm (a_den),
        .sign      (a_sign)
    );

    fp_classify u_cls_b (
        .value     (src_b),
        .dbl       (dbl),
        .is_zero   (b_zero),
        .is_inf    (b_inf),
        .is_nan    (b_nan),
        .is_snan   (b_snan),
        .is_qnan   (b_qnan),
        .is_denorm (b_den),
        .sign      (b_sign)
    );

    function automatic logic uses_b(input fp_op_t op);
        uses_b = (op == OP_ADD) || (op == OP_SUB) || (op == OP_MUL) ||
                 (op == OP_DIV) || (op == OP_CMP);
    endfunction

    // infinity or largest finite, chosen by rounding direction and sign
    function automatic logic [63:0] inf_or_max(input logic sgn, input logic [1:0] rm,
                                                input logic d);
        logic to_inf;
        to_inf = (rm == RM_NEAR) || (rm == RM_PINF && !sgn) || (rm == RM_MINF && sgn);
        if (d) begin
            inf_or_max = {sgn, to_inf ? 63'h7ff0_0000_0000_0000 : 63'h7fef_ffff_ffff_ffff};
        end else begin
            inf_or_max = {32'h0, sgn, to_inf ? 31'h7f80_0000 : 31'h7f7f_ffff};
        end
    endfunction

    // zero or smallest normal for a flushed tiny result
    function automatic logic [63:0] tiny_flush(input logic sgn, input logic [1:0] rm,
                                                input logic d);
        logic away;
        away = (rm == RM_PINF && !sgn) || (rm == RM_MINF && sgn);
        if (d) begin
            tiny_flush = {sgn, away ? 63'h0010_0000_0000_0000 : 63'h0};
        end else begin
            tiny_flush = {32'h0, sgn, away ? 31'h0080_0000 : 31'h0};
        end
    endfunction

    logic        is_arith;
    logic        is_move;
    logic        sub_eff;
    logic [4:0]  raised;
    logic        unimpl;
    logic [4:0]  enables;
    logic        trap_now;
    logic [63:0] deliver;
    logic        tiny_res;
    logic        any_snan;
    logic        any_qnan;
    logic        any_den;
    logic        aw_go;
    logic        w_go;
    logic        wr_do;
    logic [31:0] wr_word;
    logic [31:0] cause_ext;

    always_comb begin
        enables  = st_ff.csr[EN_LO +: 5];
        is_move  = (op_code == OP_MOVE);
        is_arith = (op_code inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT,
                                    OP_ABS, OP_NEG});
        any_snan = a_snan || (uses_b(op_code) && b_snan);
        any_qnan = a_qnan || (uses_b(op_code) && b_qnan);
        any_den  = a_den  || (uses_b(op_code) && b_den);
        sub_eff  = (op_code == OP_SUB) ? (a_sign == b_sign) : (a_sign != b_sign);
        raised   = 5'h0;
        unimpl   = 1'b0;

        // invalid operation
        if ((op_code == OP_ADD || op_code == OP_SUB) && a_inf && b_inf && sub_eff)
            raised[X_V] = 1'b1;
        if (op_code == OP_MUL && ((a_zero && b_inf) || (a_inf && b_zero)))
            raised[X_V] = 1'b1;
        if (op_code == OP_DIV && ((a_zero && b_zero) || (a_inf && b_inf)))
            raised[X_V] = 1'b1;
        if (op_code == OP_SQRT && a_sign && !a_zero && !a_nan)
            raised[X_V] = 1'b1;
        if (op_code == OP_CMP && cmp_signals_unordered && (a_nan || b_nan))
            raised[X_V] = 1'b1;
        if (is_arith && any_snan)
            raised[X_V] = 1'b1;
        if ((op_code == OP_CMP || op_code inside {OP_CVT_S, OP_CVT_D, OP_CVT_W, OP_CVT_L})
            && any_snan)
            raised[X_V] = 1'b1;

        // divide by zero needs finite nonzero dividend
        if (op_code == OP_DIV && b_zero && !a_zero && !a_inf && !a_nan)
            raised[X_Z] = 1'b1;

        // range flags from the datapath: overflow on unbounded-exponent rounding,
        // tiny judged on the rounded value, loss judged as inexact
        tiny_res = dp_tiny && !raised[X_V] && !raised[X_Z];
        if (dp_overflow && !raised[X_V] && !raised[X_Z]) begin
            raised[X_O] = 1'b1;
            raised[X_I] = 1'b1;
        end
        if (dp_inexact && !raised[X_V] && !raised[X_Z])
            raised[X_I] = 1'b1;
        if (tiny_res && dp_inexact)
            raised[X_U] = 1'b1;

        // unimplemented
        if (op_code == OP_RSVD || (op_fmt inside {FMT_W, FMT_L} && is_arith))
            unimpl = 1'b1;
        if ((op_code == OP_CVT_S && op_fmt == FMT_S) || (op_code == OP_CVT_D && op_fmt == FMT_D))
            unimpl = 1'b1;
        if ((is_arith || op_code inside {OP_CVT_S, OP_CVT_D, OP_CVT_W, OP_CVT_L})
            && (any_den || any_qnan))
            unimpl = 1'b1;
        if (tiny_res && (enables[X_U] || enables[X_I] || !st_ff.csr[FLUSH_SEL]))
            unimpl = 1'b1;
        else if (tiny_res)
            raised[X_I] = 1'b1;
        if (is_move) begin
            raised = 5'h0;
            unimpl = 1'b0;
        end

        // unimplemented has no enable
        trap_now = unimpl || ((raised & enables) != 5'h0);

        if (raised[X_V])
            deliver = dbl ? QNAN_D : QNAN_S;
        else if (raised[X_Z])
            deliver = dbl ? {a_sign ^ b_sign, 63'h7ff0_0000_0000_0000}
                          : {32'h0, a_sign ^ b_sign, 31'h7f80_0000};
        else if (raised[X_O])
            deliver = inf_or_max(dp_sign, st_ff.csr[RM_LO +: 2], dbl);
        else if (tiny_res)
            deliver = tiny_flush(dp_sign, st_ff.csr[RM_LO +: 2], dbl);
        else
            deliver = dp_result;

        nxt_st = st_ff;

        // verdict is registered with the write enable so both land together
        nxt_st.wb_valid    = op_valid;
        nxt_st.wb_write_en = op_valid && !trap_now && (op_code != OP_CMP);
        nxt_st.fp_trap     = op_valid && trap_now;
        nxt_st.trap_cause  = op_valid ? {unimpl, raised} : 6'h0;
        if (op_valid)
            nxt_st.wb_data = deliver;

        // axi4-lite write side: address and data accepted in either order
        aw_go = s_axi_awvalid && !st_ff.aw_held && !st_ff.bvalid;
        w_go  = s_axi_wvalid && !st_ff.w_held && !st_ff.bvalid;
        if (aw_go) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (w_go) begin
            nxt_st.w_held = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        wr_do   = st_ff.aw_held && st_ff.w_held;
        wr_word = st_ff.csr;
        for (int i = 0; i < 4; i++) begin
            if (st_ff.w_strb[i])
                wr_word[i*8 +: 8] = st_ff.w_data[i*8 +: 8];
        end
        if (wr_do) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            if (st_ff.aw_addr == OFF_CSR) begin
                nxt_st.csr   = wr_word & CSR_WMASK;
                nxt_st.bresp = RESP_OKAY;
            end else if (st_ff.aw_addr == OFF_STATUS || st_ff.aw_addr == OFF_COUNT) begin
                nxt_st.bresp = RESP_OKAY;
            end else begin
                nxt_st.bresp = RESP_SLVERR;
            end
        end
        if (st_ff.bvalid && s_axi_bready)
            nxt_st.bvalid = 1'b0;

        // hardware events win over a software write in the same cycle
        cause_ext = {20'h0, unimpl, raised, 6'h0} << (CAUSE_LO - 6);
        if (op_valid && !is_move) begin
            nxt_st.csr = nxt_st.csr | cause_ext;
            if (!trap_now)
                nxt_st.csr[FLAG_LO +: 5] = nxt_st.csr[FLAG_LO +: 5] | raised;
        end
        if (op_valid && trap_now)
            nxt_st.trap_count = st_ff.trap_count + 16'h1;

        // read side
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                OFF_CSR:    nxt_st.rdata = st_ff.csr;
                OFF_STATUS: nxt_st.rdata = {25'h0, st_ff.fp_trap, st_ff.trap_cause};
                OFF_COUNT:  nxt_st.rdata = {16'h0, st_ff.trap_count};
                default: begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff     <= '0;
            st_ff.csr <= CSR_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // write channels held off while a word waits or a response is out
    assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
    assign s_axi_wready  = !st_ff.w_held && !st_ff.bvalid;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign wb_valid      = st_ff.wb_valid;
    assign wb_write_en   = st_ff.wb_write_en;
    assign wb_data       = st_ff.wb_data;
    assign fp_trap       = st_ff.fp_trap;
    assign trap_cause    = st_ff.trap_cause;

endmodule

/* File: tb/fpu_exception_detect_asserts.sv */
// Purpose: concurrent checks on the exception unit verdict
// Assumes: single clock, sync active-low reset
// Notes:   sees only top-level ports, attached by bind
`timescale 1ns/1ps
module fpu_exc_chk
    import fpu_exc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        op_valid,
    input wire fp_op_t      op_code,
    input wire fp_fmt_t     op_fmt,
    input wire logic [63:0] src_a,
    input wire logic [63:0] src_b,
    input wire logic        wb_valid,
    input wire logic        wb_write_en,
    input wire logic [63:0] wb_data,
    input wire logic        fp_trap,
    input wire logic [5:0]  trap_cause
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic fin_a;
    // finite nonzero double dividend, denormals included
    assign fin_a = src_a[62:0] != 63'h0 && src_a[62:52] != 11'h7ff;

    verdict_next_a: assert property (op_valid |=> wb_valid &&
        (wb_write_en || fp_trap || $past(op_code) == OP_CMP)) else $error("missing verdict");
    idle_quiet_a: assert property (!op_valid |=> !wb_valid && trap_cause == 6'h0)
        else $error("verdict without issue");
    trap_nowrite_a: assert property (fp_trap |-> !wb_write_en)
        else $error("write during trap");
    move_quiet_a: assert property (op_valid && op_code == OP_MOVE
        |=> !fp_trap && trap_cause == 6'h0 && wb_write_en) else $error("move raised");
    rsvd_trap_a: assert property (op_valid && op_code == OP_RSVD
        |=> fp_trap && trap_cause[X_E]) else $error("reserved op not trapped");
    e_always_a: assert property (trap_cause[X_E] |-> fp_trap)
        else $error("unimplemented without trap");
    ovf_inexact_a: assert property (trap_cause[X_O] |-> trap_cause[X_I])
        else $error("overflow without inexact");
    dz_cause_a: assert property (op_valid && op_code == OP_DIV && op_fmt == FMT_D
        && src_b[62:0] == 63'h0 |=> trap_cause[X_Z] == $past(fin_a)) else $error("dz wrong");
    qnan_dflt_a: assert property (trap_cause[X_V] && wb_write_en
        && $past(op_code) inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT}
        |-> wb_data == ($past(op_fmt) == FMT_S ? QNAN_S : QNAN_D)) else $error("not qnan");

    cover property (fp_trap && trap_cause[X_E]);
    cover property (wb_write_en && trap_cause[X_V]);
    cover property (trap_cause[X_O] && !fp_trap);
endmodule

bind fpu_exception_detect fpu_exc_chk i_fpu_exc_chk (
    .aclk(aclk), .aresetn(aresetn), .op_valid(op_valid), .op_code(op_code),
    .op_fmt(op_fmt), .src_a(src_a), .src_b(src_b), .wb_valid(wb_valid),
    .wb_write_en(wb_write_en), .wb_data(wb_data), .fp_trap(fp_trap),
    .trap_cause(trap_cause)
);

/* File: tb/fpu_regfile_model.sv */
// Purpose: destination register and trap tally of the integer pipeline
// Assumes: one destination, written only on an allowed write-back
// Notes:   lets the bench see that a trapped op left the register alone
`timescale 1ns/1ps
module fpu_regfile_model (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        wb_valid,
    input wire logic        wb_write_en,
    input wire logic [63:0] wb_data,
    input wire logic        fp_trap,
    output logic [63:0]     dest_ff,
    output logic [7:0]      traps_ff
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dest_ff  <= 64'h0;
            traps_ff <= 8'h0;
        end else if (wb_valid) begin
            if (wb_write_en) begin
                dest_ff <= wb_data;
            end
            if (fp_trap) begin
                traps_ff <= traps_ff + 8'h1;
            end
        end
    end
endmodule

/* File: tb/fpu_exception_detect_tb_top.sv */
// Purpose: directed checks of exception verdicts and control/status word
// Assumes: verdict one cycle after issue, axi answers when it likes
// Notes:   axi readiness sampled at the falling edge to dodge races
`timescale 1ns/1ps
module fpu_exception_detect_tb_top
    import fpu_exc_pkg::*;
;
    localparam logic [63:0] ONE  = 64'h3ff0_0000_0000_0000;
    localparam logic [63:0] NEG  = 64'hbff0_0000_0000_0000;
    localparam logic [63:0] INF  = 64'h7ff0_0000_0000_0000;
    localparam logic [63:0] NINF = 64'hfff0_0000_0000_0000;
    localparam logic [63:0] SNAN = 64'h7ff4_0000_0000_0000;
    localparam logic [63:0] DEN  = 64'h0000_0000_0000_0001;
    localparam logic [63:0] MAXF = 64'h7fef_ffff_ffff_ffff;
    localparam logic [63:0] MINN = 64'h0010_0000_0000_0000;
    localparam logic [63:0] R    = 64'h4000_0000_0000_0000;
    logic        aclk, aresetn, op_valid, cmp_signals_unordered;
    logic        dp_inexact, dp_overflow, dp_tiny, dp_sign;
    fp_op_t      op_code;
    fp_fmt_t     op_fmt;
    logic [63:0] src_a, src_b, dp_result, wb_data, dest_ff;
    logic        wb_valid, wb_write_en, fp_trap;
    logic [5:0]  trap_cause;
    logic [7:0]  traps_ff, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          errors, total_checks;
    fp_op_t      vo[7] = '{OP_ADD, OP_MUL, OP_DIV, OP_DIV, OP_SQRT, OP_ABS, OP_NEG};
    logic [63:0] va[7] = '{INF, 64'h0, 64'h0, INF, NEG, SNAN, SNAN};
    logic [63:0] vb[7] = '{NINF, INF, 64'h0, INF, ONE, ONE, ONE};
    logic [63:0] ov_e[4] = '{INF, MAXF, INF, MAXF};
    logic [63:0] un_e[4] = '{64'h0, 64'h0, MINN, 64'h0};

    fpu_exception_detect i_fpu_exception_detect (
        .aclk(aclk), .aresetn(aresetn), .op_valid(op_valid), .op_code(op_code),
        .op_fmt(op_fmt), .cmp_signals_unordered(cmp_signals_unordered), .src_a(src_a),
        .src_b(src_b), .dp_result(dp_result), .dp_inexact(dp_inexact),
        .dp_overflow(dp_overflow), .dp_tiny(dp_tiny), .dp_sign(dp_sign),
        .wb_valid(wb_valid), .wb_write_en(wb_write_en), .wb_data(wb_data),
        .fp_trap(fp_trap), .trap_cause(trap_cause), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    fpu_regfile_model i_fpu_regfile_model (
        .aclk(aclk), .aresetn(aresetn), .wb_valid(wb_valid), .wb_write_en(wb_write_en),
        .wb_data(wb_data), .fp_trap(fp_trap), .dest_ff(dest_ff), .traps_ff(traps_ff)
    );

    task chk(input string n, input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task print_verdict;
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // flags fl: {unordered, overflow, tiny, inexact, sign}; ex/m: {trap, we, cause}
    task t(input fp_op_t c, input fp_fmt_t f, input logic [63:0] a, input logic [63:0] b,
           input logic [4:0] fl, input logic [7:0] ex, input logic [7:0] m);
        @(posedge aclk);
        op_code <= c;
        op_fmt <= f;
        src_a <= a;
        src_b <= b;
        {cmp_signals_unordered, dp_overflow, dp_tiny, dp_inexact, dp_sign} <= fl;
        op_valid <= 1'b1;
        @(posedge aclk);
        op_valid <= 1'b0;
        #1;
        chk("verdict", {fp_trap, wb_write_en, trap_cause} & m, ex);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !ta || s_axi_wvalid && !tw);
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", s_axi_bresp, er);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        chk("rresp", s_axi_rresp, er);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // generous bound: the directed run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        print_verdict();
    end

    initial begin
        {aresetn, op_valid, cmp_signals_unordered, dp_inexact, dp_overflow} = '0;
        {dp_tiny, dp_sign, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, src_a, src_b, s_axi_wdata} = '0;
        {s_axi_awaddr, s_axi_araddr} = '0;
        op_code = OP_ADD;
        op_fmt = FMT_D;
        s_axi_wstrb = 4'hf;
        dp_result = R;
        errors = 0;
        total_checks = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            t(vo[i], FMT_D, va[i], vb[i], 5'h0, 8'h50, 8'hff);
            chk("qnan", wb_data, QNAN_D);
        end
        t(OP_CMP, FMT_D, QNAN_D, ONE, 5'h10, 8'h10, 8'hff);
        t(OP_CMP, FMT_D, SNAN, ONE, 5'h0, 8'h10, 8'hff);
        t(OP_CVT_S, FMT_D, SNAN, ONE, 5'h0, 8'h50, 8'hff);
        t(OP_MOVE, FMT_D, DEN, ONE, 5'h0, 8'h40, 8'hff);
        t(OP_MOVE, FMT_D, SNAN, ONE, 5'h0, 8'h40, 8'hff);
        chk("move", wb_data, R);
        t(OP_DIV, FMT_D, ONE, 64'h0, 5'h0, 8'h48, 8'hff);
        chk("pinf", wb_data, INF);
        t(OP_DIV, FMT_D, NEG, 64'h0, 5'h1, 8'h48, 8'hff);
        chk("ninf", wb_data, NINF);
        t(OP_DIV, FMT_D, INF, 64'h0, 5'h0, 8'h40, 8'hff);
        t(OP_ADD, FMT_D, ONE, ONE, 5'h0a, 8'h45, 8'hff);
        t(OP_ADD, FMT_D, ONE, ONE, 5'h02, 8'h41, 8'hff);
        chk("round", wb_data, R);
        t(OP_ADD, FMT_D, ONE, ONE, 5'h06, 8'ha0, 8'he0);
        t(OP_ADD, FMT_D, DEN, ONE, 5'h0, 8'ha0, 8'he0);
        t(OP_MUL, FMT_D, QNAN_D, ONE, 5'h0, 8'ha0, 8'he0);
        t(OP_RSVD, FMT_D, ONE, ONE, 5'h0, 8'ha0, 8'he0);
        t(OP_ADD, FMT_W, ONE, ONE, 5'h0, 8'ha0, 8'he0);
        t(OP_CVT_S, FMT_S, ONE, ONE, 5'h0, 8'ha0, 8'he0);
        chk("dest", dest_ff, R);
        rd(OFF_CSR, RESP_OKAY, q);
        chk("cause", q[CAUSE_LO+:6] & 6'h3d, 6'h3d);
        // whole word written back: clears cause and flags, sets flush select
        wr(OFF_CSR, 32'h0100_0000, RESP_OKAY);
        rd(OFF_CSR, RESP_OKAY, q);
        chk("csr", q, 32'h0100_0000);
        for (int m = 0; m < 4; m++) begin
            wr(OFF_CSR, 32'h0100_0000 + 32'(m), RESP_OKAY);
            t(OP_ADD, FMT_D, ONE, ONE, 5'h0a, 8'h45, 8'hff);
            chk("ovf", wb_data, ov_e[m]);
            t(OP_ADD, FMT_D, ONE, ONE, 5'h06, 8'h43, 8'hff);
            chk("unf", wb_data, un_e[m]);
        end
        wr(OFF_CSR, 32'h0100_0b00, RESP_OKAY);
        t(OP_ADD, FMT_D, INF, NINF, 5'h0, 8'h90, 8'hff);
        t(OP_ADD, FMT_D, ONE, ONE, 5'h0a, 8'h84, 8'hc4);
        t(OP_ADD, FMT_D, ONE, ONE, 5'h06, 8'ha0, 8'he0);
        chk("dest", dest_ff, 64'h0);
        wr(OFF_COUNT, 32'hffff_ffff, RESP_OKAY);
        rd(OFF_COUNT, RESP_OKAY, q);
        chk("count", q[15:0], {8'h0, traps_ff});
        chk("traps", traps_ff, 64'h9);
        wr(8'hfc, 32'h0, RESP_SLVERR);
        rd(8'hfc, RESP_SLVERR, q);
        print_verdict();
    end
endmodule
